// ### logic/scb_pkg.sv
package scb_pkg;
  // ==========================================================
  // register addresses on the special register bus
  localparam logic [7:0] ADDR_SUPPLY_MON   = 8'he7;
  localparam logic [7:0] ADDR_EXT_IRQ_EN   = 8'he8;
  localparam logic [7:0] ADDR_PCODE_LOW    = 8'he9;
  localparam logic [7:0] ADDR_PCODE_HIGH   = 8'hea;
  localparam logic [7:0] ADDR_HW_VERSION   = 8'heb;
  localparam logic [7:0] ADDR_FLASH_CTRL   = 8'hee;
  localparam logic [7:0] ADDR_FLASH_TIMING = 8'hef;
  localparam logic [7:0] ADDR_PWR_DOWN     = 8'hf1;
  localparam logic [7:0] ADDR_STROBE_SEL   = 8'hf2;
  localparam logic [7:0] ADDR_ACLK_DIV     = 8'hf6;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_SUPPLY_MON    = 8'h00;
  localparam logic [4:0] RST_EXT_IRQ_EN    = 5'h00;
  localparam logic [7:0] EXT_IRQ_FIXED     = 8'he0;
  localparam logic [1:0] RST_FLASH_CTRL    = 2'h0;
  localparam logic [7:0] FLASH_CTRL_FIXED  = 8'h02;
  localparam logic [7:0] RST_FLASH_TIMING  = 8'ha5;
  localparam logic [4:0] RST_PWR_DOWN      = 5'h1f;
  localparam logic [5:0] RST_STROBE_SEL    = 6'h00;
  localparam logic [6:0] RST_ACLK_DIV      = 7'h03;
  // ==========================================================
  // field positions
  localparam int POS_ANA_OFF    = 7;
  localparam int POS_DIG_OFF    = 3;
  localparam int POS_PAGE_ERASE = 6;
  localparam int POS_READ_CLK   = 4;
  localparam int POS_BUSY       = 2;
  localparam int POS_CONV_OFF   = 3;
  // ==========================================================
  // fixed divides
  localparam int WRITE_MULT     = 5;
  localparam int MOD_DIV        = 64;
  // identity values, arbitrary
  localparam logic [7:0] PCODE_HIGH_VAL = 8'h5a;
  localparam logic [7:0] HW_VERSION_VAL = 8'h11;
  typedef enum logic [1:0] {FL_IDLE, FL_WRITE, FL_ERASE} scb_flash_type;
endpackage

// ### logic/scb_sfr_bank.sv
`timescale 1ns/100ps
// Overview of operation
// - analog detector enabled when bit 7 is 0; resets to 0
// - bits 6-4 select analog threshold; 111 compares analog input seven
// - digital detector enabled when bit 3 is 0; resets to 0
// - bits 2-0 select digital threshold; 111 compares analog input six
// - interrupt enable bits 7-5 read 1; bit 4 gates watchdog requests
// - interrupt enable bits 3..0 enable external lines 5..2
// - product code low reads zero above bits 1-0 flash size
// - product code high is a read-only identity byte
// - page erase select chooses byte program or page erase on moves
// - read clock mode bit selects bypass or delay line
// - busy bit 2 high during write or erase; bit 1 reads 1
// - erase lasts (1+erase count)*(ms divider+1) clocks; timing resets a5
// - write lasts (1+write count)*(us divider+1)*5 clocks
// - power down bits 4..0 switch off five peripherals; reset 1f
// - converter off also powers down reference and summation
// - strobe pin select 00x strobe, 01x clock, 10x modulator, 110/111
// - latch pin select 0x latch, 10 low, 11 high
// - analog clock = system clock/(divider+1); bit 7 reads 0; reset 03
// - modulator clock = analog clock/64; output rate by decimation
// - microsecond tick every (us divider+1) clocks
// - millisecond tick every (high*256+low+1) clocks
module scb_sfr_bank
  import scb_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        sfr_rd_i,
  output logic      [7:0]  sfr_rdata_o,
  output logic             sfr_hit_o,
  input  wire logic [1:0]  flash_size_i,
  input  wire logic [4:0]  microsecond_divider_i,
  input  wire logic [15:0] millisecond_divider_i,
  input  wire logic        flash_move_wr_i,
  output logic             flash_start_o,
  output logic             page_erase_select_o,
  output logic             flash_read_clock_mode_o,
  output logic             flash_busy_o,
  output logic             analog_detector_en_o,
  output logic [2:0]       analog_threshold_select_o,
  output logic             digital_detector_en_o,
  output logic [2:0]       digital_threshold_select_o,
  output logic             watchdog_irq_enable_o,
  output logic [3:0]       ext_irq_enable_o,
  output logic             pulse_modulator_off_o,
  output logic             converter_off_o,
  output logic             reference_off_o,
  output logic             summation_off_o,
  output logic             watchdog_off_o,
  output logic             system_timer_off_o,
  output logic             serial_peripheral_off_o,
  input  wire logic        program_strobe_i,
  input  wire logic        address_latch_i,
  output logic             program_strobe_pin_o,
  output logic             address_latch_pin_o,
  output logic             analog_clock_o,
  output logic             modulator_clock_o
);
  // ==========================================================
  // register storage
  logic [7:0]    supply_mon_r;
  logic [4:0]    ext_irq_r;
  logic [1:0]    flash_ctrl_r;
  logic [7:0]    flash_timing_r;
  logic [4:0]    pwr_down_r;
  logic [5:0]    strobe_sel_r;
  logic [6:0]    aclk_div_r;
  logic [7:0]    rdata_r;
  logic          hit_r;

  // ==========================================================
  // address decode
  wire logic wr_supply  = sfr_wr_i && (sfr_addr_i == ADDR_SUPPLY_MON);
  wire logic wr_irq     = sfr_wr_i && (sfr_addr_i == ADDR_EXT_IRQ_EN);
  wire logic wr_fctrl   = sfr_wr_i && (sfr_addr_i == ADDR_FLASH_CTRL);
  wire logic wr_ftiming = sfr_wr_i && (sfr_addr_i == ADDR_FLASH_TIMING);
  wire logic wr_pdown   = sfr_wr_i && (sfr_addr_i == ADDR_PWR_DOWN);
  wire logic wr_strobe  = sfr_wr_i && (sfr_addr_i == ADDR_STROBE_SEL);
  wire logic wr_aclk    = sfr_wr_i && (sfr_addr_i == ADDR_ACLK_DIV);

  // register writes; read-only addresses and fixed bits have no storage except strobe select bit 2, held at 0
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      supply_mon_r   <= RST_SUPPLY_MON;
      ext_irq_r      <= RST_EXT_IRQ_EN;
      flash_ctrl_r   <= RST_FLASH_CTRL;
      flash_timing_r <= RST_FLASH_TIMING;
      pwr_down_r     <= RST_PWR_DOWN;
      strobe_sel_r   <= RST_STROBE_SEL;
      aclk_div_r     <= RST_ACLK_DIV;
    end else begin
      if (wr_supply)  supply_mon_r   <= sfr_wdata_i;
      if (wr_irq)     ext_irq_r      <= sfr_wdata_i[4:0];
      if (wr_fctrl)   flash_ctrl_r   <= {sfr_wdata_i[POS_PAGE_ERASE], sfr_wdata_i[POS_READ_CLK]};
      if (wr_ftiming) flash_timing_r <= sfr_wdata_i;
      if (wr_pdown)   pwr_down_r     <= sfr_wdata_i[4:0];
      if (wr_strobe)  strobe_sel_r   <= {sfr_wdata_i[5:3], 1'b0, sfr_wdata_i[1:0]};
      if (wr_aclk)    aclk_div_r     <= sfr_wdata_i[6:0];
    end
  end

  // ==========================================================
  // flash timing engine
  scb_flash_type fl_state_r;
  logic [15:0]   fl_base_r;  // system clocks within one (divider+1) period
  logic [3:0]    fl_mult_r;  // multiplier of 5 for write units
  logic [3:0]    fl_units_r; // units still to go after the current one
  wire logic [15:0] us_unit = {11'h000, microsecond_divider_i};
  wire logic [15:0] ms_unit = millisecond_divider_i;
  wire logic        base_end = (fl_state_r == FL_WRITE) ? (fl_base_r == us_unit)
                                                        : (fl_base_r == ms_unit);
  wire logic [3:0]  mult_last = 4'(WRITE_MULT - 1);
  wire logic        unit_end = base_end && ((fl_state_r == FL_ERASE) || (fl_mult_r == mult_last));
  wire logic        start    = flash_move_wr_i && (fl_state_r == FL_IDLE);

  // one unit is (divider+1) clocks, times 5 for writes, repeated count+1 times
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      fl_state_r <= FL_IDLE;
      fl_base_r  <= 16'h0000;
      fl_mult_r  <= 4'h0;
      fl_units_r <= 4'h0;
    end else begin
      case (fl_state_r)
        FL_IDLE: begin
          fl_base_r <= 16'h0000;
          fl_mult_r <= 4'h0;
          if (start && flash_ctrl_r[1]) begin
            fl_state_r <= FL_ERASE;
            fl_units_r <= flash_timing_r[7:4];
          end else if (start) begin
            fl_state_r <= FL_WRITE;
            fl_units_r <= flash_timing_r[3:0];
          end
        end
        FL_WRITE, FL_ERASE: begin
          fl_base_r <= base_end ? 16'h0000 : fl_base_r + 16'h0001;
          if (base_end)
            fl_mult_r <= (fl_mult_r == mult_last) ? 4'h0 : fl_mult_r + 4'h1;
          if (unit_end) begin
            if (fl_units_r == 4'h0)
              fl_state_r <= FL_IDLE;
            else
              fl_units_r <= fl_units_r - 4'h1;
          end
        end
        default: fl_state_r <= FL_IDLE;
      endcase
    end
  end

  // ==========================================================
  // analog clock divider and modulator divide by 64
  logic [6:0] aclk_cnt_r;
  logic [5:0] mod_cnt_r;
  logic       aclk_r;
  logic       mod_r;
  wire logic  aclk_tick = (aclk_cnt_r >= aclk_div_r);
  localparam logic [5:0] MOD_HALF = 6'(MOD_DIV / 2 - 1);
  wire logic  mod_toggle = aclk_tick && (mod_cnt_r[4:0] == MOD_HALF[4:0]);

  // analog clock high for one system clock per (divider+1); modulator square
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || converter_off_o) begin
      aclk_cnt_r <= 7'h00;
      mod_cnt_r  <= 6'h00;
      aclk_r     <= 1'b0;
      mod_r      <= 1'b0;
    end else begin
      aclk_cnt_r <= aclk_tick ? 7'h00 : aclk_cnt_r + 7'h01;
      aclk_r     <= aclk_tick;
      if (aclk_tick) mod_cnt_r <= mod_cnt_r + 6'h01;
      if (mod_toggle) mod_r <= ~mod_r;
    end
  end

  // ==========================================================
  // pin selects
  logic strobe_pin_r;
  logic latch_pin_r;
  wire logic [2:0] ps_sel = strobe_sel_r[5:3];
  wire logic [1:0] al_sel = strobe_sel_r[1:0];
  wire logic strobe_nxt = (ps_sel[2:1] == 2'b00) ? program_strobe_i :
                          (ps_sel[2:1] == 2'b01) ? clock_i :
                          (ps_sel[2:1] == 2'b10) ? mod_r : ps_sel[0];
  wire logic latch_nxt  = al_sel[1] ? al_sel[0] : address_latch_i;

  // pin drivers; the clock selection passes straight through
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      strobe_pin_r <= 1'b0;
      latch_pin_r  <= 1'b0;
    end else begin
      strobe_pin_r <= strobe_nxt;
      latch_pin_r  <= latch_nxt;
    end
  end
  assign program_strobe_pin_o = (ps_sel[2:1] == 2'b01) ? clock_i : strobe_pin_r;
  assign address_latch_pin_o  = latch_pin_r;

  // ==========================================================
  // read mux
  wire logic [7:0] fctrl_rd = FLASH_CTRL_FIXED
                            | {1'b0, flash_ctrl_r[1], 1'b0, flash_ctrl_r[0], 4'h0}
                            | {5'h00, flash_busy_o, 2'b00};
  wire logic [7:0] rd_nxt =
    (sfr_addr_i == ADDR_SUPPLY_MON)   ? supply_mon_r :
    (sfr_addr_i == ADDR_EXT_IRQ_EN)   ? (EXT_IRQ_FIXED | {3'b000, ext_irq_r}) :
    (sfr_addr_i == ADDR_PCODE_LOW)    ? {6'h00, flash_size_i} :
    (sfr_addr_i == ADDR_PCODE_HIGH)   ? PCODE_HIGH_VAL :
    (sfr_addr_i == ADDR_HW_VERSION)   ? HW_VERSION_VAL :
    (sfr_addr_i == ADDR_FLASH_CTRL)   ? fctrl_rd :
    (sfr_addr_i == ADDR_FLASH_TIMING) ? flash_timing_r :
    (sfr_addr_i == ADDR_PWR_DOWN)     ? {3'b000, pwr_down_r} :
    (sfr_addr_i == ADDR_STROBE_SEL)   ? {2'b00, strobe_sel_r} :
    (sfr_addr_i == ADDR_ACLK_DIV)     ? {1'b0, aclk_div_r} : 8'h00;
  wire logic hit_nxt = (rd_nxt != 8'h00) || (sfr_addr_i == ADDR_SUPPLY_MON)
                    || (sfr_addr_i == ADDR_PCODE_LOW) || (sfr_addr_i == ADDR_STROBE_SEL);

  // read data registered one clock after the read strobe
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata_r <= 8'h00;
      hit_r   <= 1'b0;
    end else begin
      rdata_r <= sfr_rd_i ? rd_nxt : rdata_r;
      hit_r   <= sfr_rd_i && hit_nxt;
    end
  end

  // ==========================================================
  // control outputs
  assign sfr_rdata_o                = rdata_r;
  assign sfr_hit_o                  = hit_r;
  assign flash_start_o              = start;
  assign page_erase_select_o        = flash_ctrl_r[1];
  assign flash_read_clock_mode_o    = flash_ctrl_r[0];
  assign flash_busy_o               = (fl_state_r != FL_IDLE);
  assign analog_detector_en_o       = ~supply_mon_r[POS_ANA_OFF];
  assign analog_threshold_select_o  = supply_mon_r[6:4];
  assign digital_detector_en_o      = ~supply_mon_r[POS_DIG_OFF];
  assign digital_threshold_select_o = supply_mon_r[2:0];
  assign watchdog_irq_enable_o      = ext_irq_r[4];
  assign ext_irq_enable_o           = ext_irq_r[3:0];
  assign pulse_modulator_off_o      = pwr_down_r[4];
  assign converter_off_o            = pwr_down_r[POS_CONV_OFF];
  assign reference_off_o            = pwr_down_r[POS_CONV_OFF];
  assign summation_off_o            = pwr_down_r[POS_CONV_OFF];
  assign watchdog_off_o             = pwr_down_r[2];
  assign system_timer_off_o         = pwr_down_r[1];
  assign serial_peripheral_off_o    = pwr_down_r[0];
  assign analog_clock_o             = aclk_r;
  assign modulator_clock_o          = mod_r;

  // ==========================================================
  // checks
  a_busy_on_start: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    start |=> flash_busy_o) else $error("busy not raised after start");
  a_irq_fixed_bits: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sfr_rd_i && sfr_addr_i == ADDR_EXT_IRQ_EN |=> sfr_rdata_o[7:5] == 3'b111)
    else $error("fixed enable bits not one");
  a_aclk_low_bit7: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sfr_rd_i && sfr_addr_i == ADDR_ACLK_DIV |=> !sfr_rdata_o[7])
    else $error("divider bit 7 not zero");
  a_pcode_low_top: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sfr_rd_i && sfr_addr_i == ADDR_PCODE_LOW |=> sfr_rdata_o == {6'h00, $past(flash_size_i)})
    else $error("product code low wrong");
  a_det_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_supply |=> analog_detector_en_o == !$past(sfr_wdata_i[7])
                  && digital_detector_en_o == !$past(sfr_wdata_i[3]))
    else $error("detector enable wrong");
  a_conv_group: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_pdown |=> reference_off_o == $past(sfr_wdata_i[3]) && summation_off_o == converter_off_o)
    else $error("converter group mismatch");
  a_latch_forced: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    al_sel == 2'b11 && $past(al_sel) == 2'b11 |-> address_latch_pin_o)
    else $error("latch pin not held high");
  a_min_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    start && !flash_ctrl_r[1] |=> flash_busy_o [*5])
    else $error("write ended too early");
  a_ro_ignored: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sfr_rd_i && sfr_addr_i == ADDR_PCODE_HIGH |=> sfr_rdata_o == PCODE_HIGH_VAL)
    else $error("product code high changed");
endmodule // scb_sfr_bank

// ### sim/scb_cpu_model.sv
`timescale 1ns/100ps
// ==========================================================
// core side of the register bus, one access per task call
module scb_cpu_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] sfr_rdata_i,
  output logic      [7:0] sfr_addr_o,
  output logic            sfr_wr_o,
  output logic      [7:0] sfr_wdata_o,
  output logic            sfr_rd_o
);
  // quiet bus at time zero
  initial begin
    sfr_addr_o = 8'h00;
    sfr_wr_o = 1'b0;
    sfr_wdata_o = 8'h00;
    sfr_rd_o = 1'b0;
  end

  // write: held until the taking edge, then inverted so nothing stale lingers
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    sfr_addr_o <= a;
    sfr_wdata_o <= v;
    sfr_wr_o <= 1'b1;
    @(posedge clock_i);
    sfr_wr_o <= 1'b0;
    sfr_addr_o <= ~a;
    sfr_wdata_o <= ~v;
  endtask

  // read: data is registered at the taking edge and sampled 1 ns after it
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    sfr_addr_o <= a;
    sfr_rd_o <= 1'b1;
    @(posedge clock_i);
    sfr_rd_o <= 1'b0;
    sfr_addr_o <= ~a;
    #1;
    v = sfr_rdata_i;
  endtask
endmodule // scb_cpu_model

// ### sim/system_control_sfr_bank_test.sv
`timescale 1ns/100ps
module system_control_sfr_bank_test;
  import scb_pkg::*;
  // ==========================================================
  // signals, named as the block's ports
  logic        clock_i = 1'b0, rst_n_i = 1'b0, flash_move_wr_i = 1'b0;
  logic        program_strobe_i = 1'b0, address_latch_i = 1'b0;
  logic [1:0]  flash_size_i = 2'h2;
  logic [4:0]  microsecond_divider_i = 5'h02;
  logic [15:0] millisecond_divider_i = 16'h0104;
  logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, d;
  logic        sfr_wr_i, sfr_rd_i, sfr_hit_o, flash_start_o, flash_busy_o;
  logic        page_erase_select_o, flash_read_clock_mode_o, watchdog_irq_enable_o;
  logic        analog_detector_en_o, digital_detector_en_o, pulse_modulator_off_o;
  logic [2:0]  analog_threshold_select_o, digital_threshold_select_o;
  logic [3:0]  ext_irq_enable_o;
  logic        converter_off_o, reference_off_o, summation_off_o, watchdog_off_o;
  logic        system_timer_off_o, serial_peripheral_off_o, program_strobe_pin_o;
  logic        address_latch_pin_o, analog_clock_o, modulator_clock_o;
  int          fails = 0, checks = 0;

  scb_sfr_bank i_dut (.*);
  scb_cpu_model i_cpu (.clock_i(clock_i), .sfr_rdata_i(sfr_rdata_o), .sfr_addr_o(sfr_addr_i),
    .sfr_wr_o(sfr_wr_i), .sfr_wdata_o(sfr_wdata_i), .sfr_rd_o(sfr_rd_i));

  // 125 MHz system clock
  always #4 clock_i = ~clock_i;

  // ==========================================================
  // compare and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    i_cpu.rd(a, d);
    chk(d, e);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rdchk(ADDR_SUPPLY_MON, 8'h00);
    rdchk(ADDR_EXT_IRQ_EN, 8'he0);
    rdchk(ADDR_PCODE_LOW, 8'h02);
    rdchk(ADDR_FLASH_CTRL, 8'h02);
    rdchk(ADDR_FLASH_TIMING, 8'ha5);
    rdchk(ADDR_PWR_DOWN, 8'h1f);
    rdchk(ADDR_STROBE_SEL, 8'h00);
    rdchk(ADDR_ACLK_DIV, 8'h03);
    chk(sfr_hit_o, 1'b1);
    rdchk(8'hf0, 8'h00);
    chk(sfr_hit_o, 1'b0);
    chk({analog_detector_en_o, digital_detector_en_o, converter_off_o}, 3'h7);
    $display("reset values done");
  endtask

  task automatic t_detect;
    for (int c = 0; c < 8; c++) begin
      i_cpu.wr(ADDR_SUPPLY_MON, {c[0], c[2:0], c[1], ~c[2:0]});
      #1;
      chk({analog_detector_en_o, analog_threshold_select_o, digital_detector_en_o,
        digital_threshold_select_o}, {~c[0], c[2:0], ~c[1], ~c[2:0]});
    end
    rdchk(ADDR_SUPPLY_MON, 8'hf8);
    i_cpu.wr(ADDR_SUPPLY_MON, 8'h88);
    #1 chk({analog_detector_en_o, digital_detector_en_o}, 2'h0);
    $display("supply detector done");
  endtask

  task automatic t_irq;
    i_cpu.wr(ADDR_EXT_IRQ_EN, 8'h0a);
    #1 chk({watchdog_irq_enable_o, ext_irq_enable_o}, 5'h0a);
    rdchk(ADDR_EXT_IRQ_EN, 8'hea);
    i_cpu.wr(ADDR_EXT_IRQ_EN, 8'h15);
    #1 chk({watchdog_irq_enable_o, ext_irq_enable_o}, 5'h15);
    $display("interrupt enable done");
  endtask

  task automatic t_fixed;
    for (int s = 0; s < 4; s++) begin
      @(posedge clock_i) flash_size_i <= s[1:0];
      i_cpu.wr(ADDR_PCODE_LOW, 8'hff);
      rdchk(ADDR_PCODE_LOW, {6'h00, s[1:0]});
    end
    i_cpu.wr(ADDR_PCODE_HIGH, 8'h00);
    rdchk(ADDR_PCODE_HIGH, PCODE_HIGH_VAL);
    i_cpu.wr(ADDR_HW_VERSION, 8'h00);
    rdchk(ADDR_HW_VERSION, HW_VERSION_VAL);
    i_cpu.wr(ADDR_FLASH_CTRL, 8'hff);
    rdchk(ADDR_FLASH_CTRL, 8'h52);
    chk({page_erase_select_o, flash_read_clock_mode_o}, 2'h3);
    i_cpu.wr(ADDR_ACLK_DIV, 8'hff);
    rdchk(ADDR_ACLK_DIV, 8'h7f);
    $display("read-only and fixed bits done");
  endtask

  // one flash operation; a second move mid-operation must be ignored
  task automatic t_flash(input logic erase, input logic [7:0] tim, input int n);
    int cnt;
    i_cpu.wr(ADDR_FLASH_CTRL, {1'b0, erase, 6'h00});
    i_cpu.wr(ADDR_FLASH_TIMING, tim);
    @(posedge clock_i) flash_move_wr_i <= 1'b1;
    #1 chk(flash_start_o, 1'b1);
    @(posedge clock_i) flash_move_wr_i <= 1'b0;
    #1 cnt = 0;
    while (flash_busy_o === 1'b1 && cnt < 3000) begin
      cnt++;
      if (cnt == 3)
        chk(flash_start_o, 1'b0);
      @(posedge clock_i) flash_move_wr_i <= (cnt == 2);
      #1;
    end
    chk(cnt[15:0], n[15:0]);
    rdchk(ADDR_FLASH_CTRL, {1'b0, erase, 6'h02});
    $display("flash operation done");
  endtask

  task automatic t_pdown;
    logic [4:0] m;
    for (int i = 0; i < 5; i++) begin
      m = 5'h01 << i;
      i_cpu.wr(ADDR_PWR_DOWN, {3'h0, m});
      #1 chk({pulse_modulator_off_o, converter_off_o, watchdog_off_o, system_timer_off_o,
        serial_peripheral_off_o, reference_off_o, summation_off_o}, {m, {2{m[3]}}});
    end
    i_cpu.wr(ADDR_PWR_DOWN, 8'hff);
    rdchk(ADDR_PWR_DOWN, 8'h1f);
    $display("power down done");
  endtask

  // converter is off here, so the modulator selection shows low
  task automatic t_pins;
    logic pe, ae;
    for (int c = 0; c < 8; c++) begin
      i_cpu.wr(ADDR_STROBE_SEL, {2'h0, c[2:0], 1'b0, c[1:0]});
      for (int v = 1; v >= 0; v--) begin
        @(posedge clock_i);
        program_strobe_i <= v[0];
        address_latch_i <= v[0];
        repeat (2) @(posedge clock_i);
        #1 pe = (c[2:1] == 2'h0) ? v[0] : (c[2:1] == 2'h1) ? 1'b1 : (c[2:1] == 2'h3) & c[0];
        ae = c[1] ? c[0] : v[0];
        chk({program_strobe_pin_o, address_latch_pin_o}, {pe, ae});
      end
    end
    $display("pin select done");
  endtask

  task automatic wait_rise(output int n);
    n = 0;
    do begin
      @(posedge clock_i) #1 n++;
    end while (!(modulator_clock_o === 1'b1 && n > 1) && n < 600);
    while (modulator_clock_o === 1'b1 && n < 600) @(posedge clock_i) #1 n++;
  endtask

  task automatic t_aclk;
    int n;
    i_cpu.wr(ADDR_PWR_DOWN, 8'h17);
    i_cpu.wr(ADDR_ACLK_DIV, 8'h02);
    n = 0;
    repeat (30) @(posedge clock_i) #1 n += (analog_clock_o === 1'b1);
    chk(n[15:0], 16'd10);
    wait_rise(n);
    wait_rise(n);
    chk(n[15:0], 16'(MOD_DIV * 3));
    $display("analog clock done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_detect();
    t_irq();
    t_fixed();
    t_flash(1'b0, 8'ha1, 2 * 3 * WRITE_MULT);
    t_flash(1'b1, 8'h25, 3 * 261);
    t_pdown();
    t_pins();
    t_aclk();
    tally_and_finish();
  end
  initial begin
    #(8 * 20000);
    fails++;
    tally_and_finish();
  end
endmodule // system_control_sfr_bank_test
